// File: common/spi_sel_pkg.sv
// constants of the serial memory select and output control block
package spi_sel_pkg;
	// *****************************
	// clock and write timing
	// *****************************
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned TWC_MAX_MS    = 5;
	localparam int unsigned WRITE_CYCLES  = (TWC_MAX_MS * CLK_HZ) / 1000;
	// *****************************
	// serial framing
	// *****************************
	localparam int unsigned BYTE_BITS     = 8;
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	localparam logic [2:0]  BYTE_ADDR_LO  = 3'h2;
	localparam logic [2:0]  BYTE_WREN_END = 3'h1;
	localparam logic [2:0]  BYTE_DATA_MIN = 3'h4;
	// *****************************
	// instruction codes
	// *****************************
	localparam logic [7:0]  OP_READ       = 8'h03;
	localparam logic [7:0]  OP_WRITE      = 8'h02;
	localparam logic [7:0]  OP_WREN       = 8'h06;
	localparam logic [7:0]  OP_WRDI       = 8'h04;
	// *****************************
	// pin synchroniser lanes
	// *****************************
	localparam int unsigned PIN_N         = 4;
	localparam int unsigned PIN_CS        = 0;
	localparam int unsigned PIN_SCK       = 1;
	localparam int unsigned PIN_SI        = 2;
	localparam int unsigned PIN_HOLD      = 3;
	localparam logic [3:0]  PIN_RST       = 4'hD;
endpackage

// File: rtl/pin_sync.sv
// two-stage pin synchroniser with edge detection per lane
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned  N         = 4,
	parameter logic [N-1:0] RST_VAL   = '0
) (
	input  wire logic         CLK,
	input  wire logic         RST_B,
	input  wire logic [N-1:0] PIN,
	output logic      [N-1:0] LVL,
	output logic      [N-1:0] RISE,
	output logic      [N-1:0] FALL
);
	logic [N-1:0] meta_reg;
	logic [N-1:0] sync_reg;
	logic [N-1:0] last_reg;

	// *****************************
	// per lane: first flop feeds only the second
	// *****************************
	for (genvar i = 0; i < N; i++) begin : g_lane
		always_ff @(posedge CLK or negedge RST_B) begin
			if (!RST_B) begin
				meta_reg[i] <= RST_VAL[i];
				sync_reg[i] <= RST_VAL[i];
				last_reg[i] <= RST_VAL[i];
			end else begin
				meta_reg[i] <= PIN[i];
				sync_reg[i] <= meta_reg[i];
				last_reg[i] <= sync_reg[i];
			end
		end
		assign LVL[i]  = sync_reg[i];
		assign RISE[i] = sync_reg[i] & ~last_reg[i];
		assign FALL[i] = ~sync_reg[i] & last_reg[i];
	end
endmodule // pin_sync

// File: rtl/spi_sel_out_ctrl.sv
// select, standby, write cycle and serial output control of a serial memory
// *****************************
// Functional notes
// (R1) selected and accepting bus activity only while chip select is low
// (R2) chip select high deselects and enters standby unless a write cycle runs
// (R3) a started write cycle runs to its end whatever chip select does
// (R4) standby after deselect waits until the running write cycle is finished
// (R5) serial output is high impedance whenever deselected
// (R6) write cycle starts on chip select rising after a complete valid write sequence
// (R7) after power-up nothing is accepted until a chip select falling edge; the CS lane resets high, so CS held low at reset also arms the block
// (R8) read data bits change on the output after serial clock falling edges
// (R9) serial input bits are captured on serial clock rising edges
// (R10) bytes travel most significant bit first
// (R11) pause input low puts the serial output into high impedance
// (R12) the write enable latch clears when the write cycle completes
// (R13) the write cycle is timed internally and ends within the maximum write time
// *****************************
`timescale 1ns/1ps
module spi_sel_out_ctrl #(
	parameter int unsigned WRITE_CYCLES = spi_sel_pkg::WRITE_CYCLES
) (
	input  wire logic       CLK,
	input  wire logic       RST_B,
	input  wire logic       CS_B,
	input  wire logic       SCK,
	input  wire logic       SI,
	input  wire logic       HOLD_B,
	input  wire logic [7:0] TX_DATA,
	output logic            TX_LOAD,
	output logic            SO,
	output logic            SO_OE,
	output logic [7:0]      RX_BYTE,
	output logic            RX_VALID,
	output logic            WR_START,
	output logic            WIP,
	output logic            WEL,
	output logic            STANDBY
);
	localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);
	localparam logic [CW-1:0] WC_LAST = CW'(WRITE_CYCLES - 1);

	logic [spi_sel_pkg::PIN_N-1:0] lvl, rise, fall;
	logic       cs_s, hold_s, si_s, cs_rise, cs_fall, sck_rise, sck_fall;
	logic       armed_reg, sel, rx_edge, tx_edge, byte_done;
	logic [2:0] bit_cnt_reg, byte_cnt_reg, out_cnt_reg;
	logic [7:0] shift_reg, shift_next, opcode_reg, tx_shift_reg;
	logic       rd_reg, so_reg, wip_reg, wel_reg, wr_start_reg, rx_valid_reg;
	logic [7:0] rx_byte_reg;
	logic [CW-1:0] wc_cnt_reg;
	logic       write_ok, wren_ok;

	pin_sync #(
		.N       (spi_sel_pkg::PIN_N),
		.RST_VAL (spi_sel_pkg::PIN_RST)
	) u_sync (
		.CLK   (CLK),
		.RST_B (RST_B),
		.PIN   ({HOLD_B, SI, SCK, CS_B}),
		.LVL   (lvl),
		.RISE  (rise),
		.FALL  (fall)
	);

	assign cs_s     = lvl[spi_sel_pkg::PIN_CS];
	assign hold_s   = lvl[spi_sel_pkg::PIN_HOLD];
	assign si_s     = lvl[spi_sel_pkg::PIN_SI];
	assign cs_rise  = rise[spi_sel_pkg::PIN_CS];
	assign cs_fall  = fall[spi_sel_pkg::PIN_CS];
	assign sck_rise = rise[spi_sel_pkg::PIN_SCK];
	assign sck_fall = fall[spi_sel_pkg::PIN_SCK];

	// *****************************
	// selection
	// *****************************
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			armed_reg <= 1'b0;
		else if (cs_fall)
			armed_reg <= 1'b1; // [R7]
	end

	// commands are refused while a write cycle runs; the host should poll elsewhere
	assign sel        = ~cs_s & armed_reg & ~wip_reg; // [R1] [R7]
	assign rx_edge    = sel & hold_s & sck_rise; // [R9]
	assign tx_edge    = sel & hold_s & sck_fall & rd_reg; // [R8]
	assign shift_next = {shift_reg[6:0], si_s}; // [R10]
	assign byte_done  = rx_edge & (bit_cnt_reg == spi_sel_pkg::BIT_LAST);

	// *****************************
	// input framing
	// *****************************
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
			shift_reg    <= 8'h00;
			opcode_reg   <= 8'h00;
		end else if (cs_s) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
		end else if (rx_edge) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg   <= shift_next;
			if (byte_done && byte_cnt_reg == 3'h0)
				opcode_reg <= shift_next;
			if (byte_done && byte_cnt_reg != spi_sel_pkg::BYTE_DATA_MIN)
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_byte_reg  <= 8'h00;
			rx_valid_reg <= 1'b0;
		end else begin
			rx_valid_reg <= byte_done;
			if (byte_done)
				rx_byte_reg <= shift_next;
		end
	end

	// *****************************
	// read output
	// *****************************
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			rd_reg <= 1'b0;
		else if (cs_s)
			rd_reg <= 1'b0;
		else if (byte_done && byte_cnt_reg == spi_sel_pkg::BYTE_ADDR_LO && opcode_reg == spi_sel_pkg::OP_READ)
			rd_reg <= 1'b1;
	end

	assign TX_LOAD = tx_edge & (out_cnt_reg == 3'h0);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_cnt_reg  <= 3'h0;
			tx_shift_reg <= 8'h00;
			so_reg       <= 1'b0;
		end else if (!rd_reg) begin
			out_cnt_reg <= 3'h0;
		end else if (tx_edge) begin
			out_cnt_reg <= out_cnt_reg + 3'h1;
			if (out_cnt_reg == 3'h0) begin
				so_reg       <= TX_DATA[7]; // [R8] [R10]
				tx_shift_reg <= {TX_DATA[6:0], 1'b0};
			end else begin
				so_reg       <= tx_shift_reg[7]; // [R8]
				tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
			end
		end
	end

	// *****************************
	// write cycle
	// *****************************
	// cs_s already reads high on the cs_rise cycle, so sel cannot qualify the closing edge;
	// the frame counters still hold the closing frame there and clear one cycle later
	assign write_ok = armed_reg & ~wip_reg & cs_rise & wel_reg & (opcode_reg == spi_sel_pkg::OP_WRITE)
	                & (byte_cnt_reg == spi_sel_pkg::BYTE_DATA_MIN) & (bit_cnt_reg == 3'h0); // [R6]
	assign wren_ok  = armed_reg & ~wip_reg & cs_rise & (opcode_reg == spi_sel_pkg::OP_WREN)
	                & (byte_cnt_reg == spi_sel_pkg::BYTE_WREN_END) & (bit_cnt_reg == 3'h0);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wip_reg      <= 1'b0;
			wc_cnt_reg   <= '0;
			wr_start_reg <= 1'b0;
		end else begin
			wr_start_reg <= write_ok;
			if (write_ok) begin
				wip_reg    <= 1'b1; // [R6]
				wc_cnt_reg <= '0;
			end else if (wip_reg) begin
				wc_cnt_reg <= wc_cnt_reg + CW'(1); // [R3] [R13]
				if (wc_cnt_reg == WC_LAST)
					wip_reg <= 1'b0; // [R13]
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			wel_reg <= 1'b0;
		else if (wip_reg && wc_cnt_reg == WC_LAST)
			wel_reg <= 1'b0; // [R12]
		else if (wren_ok)
			wel_reg <= 1'b1;
		else if (byte_done && byte_cnt_reg == 3'h0 && shift_next == spi_sel_pkg::OP_WRDI)
			wel_reg <= 1'b0;
	end

	// *****************************
	// outputs
	// *****************************
	assign SO       = so_reg;
	assign SO_OE    = sel & hold_s & rd_reg; // [R5] [R11]
	assign RX_BYTE  = rx_byte_reg;
	assign RX_VALID = rx_valid_reg;
	assign WR_START = wr_start_reg;
	assign WIP      = wip_reg;
	assign WEL      = wel_reg;
	assign STANDBY  = (cs_s | ~armed_reg) & ~wip_reg; // [R2] [R4]

	// *****************************
	// assertions
	// *****************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	a_no_standby_busy: assert property (wip_reg |-> !STANDBY) // [R2] [R4]
		else $error("standby while write cycle runs");
	a_write_start: assert property (write_ok |=> wip_reg && WR_START && wc_cnt_reg == '0) // [R6]
		else $error("write cycle did not start on select release");
	a_write_runs: assert property ($rose(wip_reg) |-> wip_reg[*8]) // [R3]
		else $error("write cycle ended early");
	a_write_ends: assert property (wip_reg && wc_cnt_reg == WC_LAST |=> !wip_reg && !wel_reg) // [R12] [R13]
		else $error("write cycle not finished on time or latch kept");
	a_deselect_hiz: assert property (cs_s |-> !SO_OE) // [R5]
		else $error("output driven while deselected");
	a_pause_hiz: assert property (!hold_s |-> !SO_OE) // [R11]
		else $error("output driven while paused");
	a_powerup_idle: assert property (!armed_reg |-> !rd_reg && !wip_reg && !wel_reg) // [R7]
		else $error("activity before first select");
	a_out_on_fall: assert property ($changed(so_reg) |-> $past(sck_fall)) // [R8]
		else $error("output bit changed off a falling clock edge");
	a_capture_lsb: assert property (RX_VALID |-> $past(sck_rise) && RX_BYTE[0] == $past(si_s)) // [R9] [R10]
		else $error("byte not captured on rising edge");
	a_select_gate: assert property (cs_s |=> $stable(bit_cnt_reg) || bit_cnt_reg == 3'h0) // [R1]
		else $error("bits counted while deselected");

	c_write: cover property (write_ok ##1 wip_reg);
	c_read: cover property (TX_LOAD ##[1:200] SO_OE);
	c_wren: cover property (wren_ok);
endmodule // spi_sel_out_ctrl

// File: test/spi_master_model.sv
// bus master model driving select, serial clock, serial input and pause pins
`timescale 1ns/1ps
module spi_master_model (
	input  wire logic CLK,
	input  wire logic SO,
	input  wire logic SO_OE,
	output logic      CS_B,
	output logic      SCK,
	output logic      SI,
	output logic      HOLD_B
);
	logic last_so;
	logic so_line;
	// a released output shows the inverse of its last value, so a stale level never passes
	always_comb so_line = SO_OE ? SO : ~last_so;
	initial begin
		CS_B = 1'b1;
		SCK = 1'b0;
		SI = 1'b1;
		HOLD_B = 1'b1;
		last_so = 1'b0;
	end
	// pins change only at falling edges of the system clock, 4 cycles per serial half period
	task automatic half();
		repeat (4) @(negedge CLK);
	endtask
	// the first select is a falling edge, as the device needs after power-up
	task automatic select(input logic lvl);
		half();
		CS_B = lvl;
	endtask
	task automatic pause(input logic lvl);
		HOLD_B = lvl;
		half();
	endtask
	// serial clock idles low between frames; output sampled late in the high phase
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			SI = tx[i];
			half();
			SCK = 1'b1;
			half();
			rx[i] = so_line;
			last_so = so_line;
			SCK = 1'b0;
		end
	endtask
endmodule // spi_master_model

// File: test/spi_sel_out_ctrl_tb_top.sv
// self-checking bench of the select and serial output control block
`timescale 1ns/1ps
`define CHK(name, exp, got) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("BAD %s expected %h seen %h", name, exp, got); \
	end \
end
module spi_sel_out_ctrl_tb_top;
	// shortened write cycle keeps the run brief
	localparam int unsigned WCYC = 40;
	logic       clk;
	logic       rst_b;
	logic       cs_b, sck, si, hold_b, so, so_oe, tx_load, rx_valid, wr_start, wip, wel, standby;
	logic [7:0] rx_byte;
	logic [7:0] rx;
	logic [7:0] tx_data = 8'hA5;
	bit         seen;
	int         loads = 0;
	int         rx_count = 0;
	int         miscompares = 0;
	int         total_checks = 0;
	int         cycles = 0;
	spi_sel_out_ctrl #(.WRITE_CYCLES(WCYC)) dut (.CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCK(sck), .SI(si),
		.HOLD_B(hold_b), .TX_DATA(tx_data), .TX_LOAD(tx_load), .SO(so), .SO_OE(so_oe), .RX_BYTE(rx_byte),
		.RX_VALID(rx_valid), .WR_START(wr_start), .WIP(wip), .WEL(wel), .STANDBY(standby));
	spi_master_model m (.CLK(clk), .SO(so), .SO_OE(so_oe), .CS_B(cs_b), .SCK(sck), .SI(si), .HOLD_B(hold_b));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// a hang is cut short well past the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	// one-cycle pulses counted mid-cycle, away from the edge that launches them
	always @(negedge clk) begin
		if (tx_load === 1'b1)
			loads++;
		if (rx_valid === 1'b1)
			rx_count++;
	end
	task automatic t_powerup();
		`CHK("standby at power-up", 1'b1, standby)
		`CHK("latch at power-up", 1'b0, wel)
		`CHK("drive at power-up", 1'b0, so_oe)
		$display("test power-up done");
	endtask
	task automatic wait_start(output bit got);
		got = 1'b0;
		repeat (20) begin
			@(negedge clk);
			if (wr_start === 1'b1)
				got = 1'b1;
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		m.select(1'b0);
		m.xfer(op, rx);
		m.select(1'b1);
		repeat (6) @(negedge clk);
	endtask
	task automatic t_read();
		m.select(1'b0);
		m.xfer(spi_sel_pkg::OP_READ, rx);
		m.xfer(8'h00, rx);
		m.xfer(8'h20, rx);
		m.xfer(8'h00, rx);
		`CHK("read byte", 8'hA5, rx)
		// next byte is taken at the falling edge that closed the last one
		tx_data = 8'h3C;
		m.xfer(8'h00, rx);
		`CHK("second read byte", 8'h3C, rx)
		`CHK("byte loads", 2, loads)
		`CHK("drive selected", 1'b1, so_oe)
		m.pause(1'b0);
		`CHK("drive paused", 1'b0, so_oe)
		m.pause(1'b1);
		m.select(1'b1);
		repeat (4) @(negedge clk);
		`CHK("drive deselected", 1'b0, so_oe)
		$display("test read done");
	endtask
	task automatic t_write();
		int n0;
		cmd(spi_sel_pkg::OP_WREN);
		`CHK("latch set", 1'b1, wel)
		`CHK("standby idle", 1'b1, standby)
		n0 = rx_count;
		m.select(1'b0);
		m.xfer(spi_sel_pkg::OP_WRITE, rx);
		m.xfer(8'h00, rx);
		m.xfer(8'h10, rx);
		m.xfer(8'h5A, rx);
		m.select(1'b1);
		wait_start(seen);
		`CHK("received byte", 8'h5A, rx_byte)
		`CHK("bytes received", 4, rx_count - n0)
		`CHK("write start", 1'b1, seen)
		`CHK("standby in write", 1'b0, standby)
		// select toggled mid-cycle must neither stop the cycle nor allow standby
		m.select(1'b0);
		m.select(1'b1);
		@(negedge clk);
		`CHK("busy after toggle", 1'b1, wip)
		`CHK("no standby yet", 1'b0, standby)
		repeat (WCYC) @(negedge clk);
		`CHK("cycle ended", 1'b0, wip)
		`CHK("latch cleared", 1'b0, wel)
		`CHK("standby after", 1'b1, standby)
		$display("test write done");
	endtask
	task automatic t_refused();
		cmd(spi_sel_pkg::OP_WREN);
		cmd(spi_sel_pkg::OP_WRDI);
		`CHK("latch off", 1'b0, wel)
		m.select(1'b0);
		m.xfer(spi_sel_pkg::OP_WRITE, rx);
		m.xfer(8'h00, rx);
		m.xfer(8'h11, rx);
		m.xfer(8'hC3, rx);
		m.select(1'b1);
		wait_start(seen);
		`CHK("no start", 1'b0, seen)
		`CHK("not busy", 1'b0, wip)
		$display("test refused write done");
	endtask
	initial begin
		rst_b = 1'b0;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_powerup();
		t_read();
		t_write();
		t_refused();
		complete_run();
	end
endmodule // spi_sel_out_ctrl_tb_top
